/* core/qdac_pkg.sv */
package qdac_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 20;
  // typical exit from power-down at 5 V; 3 V parts need about 5000 ns
  localparam int PD_EXIT_NS = 2500;
  localparam int PD_EXIT_CYC = (PD_EXIT_NS * CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // two-wire addressing and field positions
  // ----------------------------------------------------------------
  localparam logic [5:0] SLV_ADDR_HI = 6'h06;
  localparam int CW_POWERDOWN_MODE_HI = 15;
  localparam int CW_POWERDOWN_MODE_LO = 14;
  localparam int CW_CLEAR_ALL_BIT = 13;
  localparam int CW_LOAD_OUTPUTS_BIT = 12;
  localparam int PB_RIGHT = 5;
  localparam int PB_SINGLE = 4;
  localparam int PB_CHANNEL_D_SELECT = 3;
  localparam int PB_CHANNEL_A_SELECT = 0;

  // ----------------------------------------------------------------
  // reset values and fixed patterns
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [15:0] RB_DEFAULT_DBL = 16'h2000;
  localparam logic [15:0] RB_DEFAULT_SGL = 16'h0000;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [2:0] PIN_RST = 3'h3;

  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_TRISTATE = 2'h3;

  // ----------------------------------------------------------------
  // wishbone register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STAT = 8'h04;
  localparam logic [3:0] ADR_DAC_PAGE = 4'h1;
  localparam logic [3:0] ADR_INP_PAGE = 4'h2;
  localparam int CTRL_EN_POS = 0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK = 6'h04,
    ST_RX = 6'h08,
    ST_TX = 6'h10,
    ST_MACK = 6'h20
  } qdac_st_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } qdac_wb_req_s;

endpackage : qdac_pkg

/* core/qdac_core.sv */
// Register access over Wishbone and the placing of the registers were decided locally.
module qdac_core #(
  parameter int DATA_W = 12,
  parameter int EXIT_CYC = qdac_pkg::PD_EXIT_CYC
) (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // wishbone slave
  input wire qdac_pkg::qdac_wb_req_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // two-wire link
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic address_select_pin_i,
  // converter side
  output logic [3:0][DATA_W-1:0] dac_code_o,
  output logic [1:0] pd_mode_o,
  output logic out_active_o
);
  import qdac_pkg::*;

  localparam int EXW = $clog2(EXIT_CYC + 1);

  if (!(DATA_W == 8 || DATA_W == 10 || DATA_W == 12) || EXIT_CYC < 1)
  begin : g_chk
    $error("qdac_core: DATA_W must be 8, 10 or 12, EXIT_CYC above 0");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  // pin bit 0 scl, bit 1 sda, bit 2 address select
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] filt;
    qdac_st_e st;
    logic [3:0] bitcnt;
    logic [7:0] sh;
    logic rw;
    logic [1:0] idx;
    logic wr_ok;
    logic [15:0] word;
    logic [7:0] ptr;
    logic txsel;
    logic mack;
    logic sda_oe_n;
    logic [3:0][DATA_W-1:0] inreg;
    logic [3:0][DATA_W-1:0] dacreg;
    logic [3:0] dirty;
    logic [1:0] pd;
    logic [EXW-1:0] exit_cnt;
    logic active;
    logic en;
    logic ack;
    logic [31:0] rdat;
  } qdac_state_s;

  qdac_state_s r_r;
  qdac_state_s r_nxt;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [1:0] chan_index(input logic [3:0] sel);
    logic [1:0] i;
    i = 2'h0;
    case (sel)
      4'h2: i = 2'h1;
      4'h4: i = 2'h2;
      4'h8: i = 2'h3;
      default: i = 2'h0;
    endcase
    return i;
  endfunction : chan_index

  // code carried by a received word under the current pointer format
  function automatic logic [DATA_W-1:0] decode_data(
    input logic [7:0] p,
    input logic [15:0] w
  );
    logic [DATA_W-1:0] d;
    if (p[PB_SINGLE]) begin
      d = DATA_W'(w[15:8]) << (DATA_W - 8);
    end else if (p[PB_RIGHT]) begin
      d = w[DATA_W-1:0];
    end else begin
      d = w[11 -: DATA_W];
    end
    return d;
  endfunction : decode_data

  // readback word; a single-byte answer sits in the top byte
  function automatic logic [15:0] rb_word(
    input logic [7:0] p,
    input logic [3:0][DATA_W-1:0] regs,
    input logic [1:0] pd
  );
    logic [3:0] sel;
    logic one;
    logic [DATA_W-1:0] d;
    logic [15:0] ctl;
    logic [15:0] w;
    sel = p[PB_CHANNEL_D_SELECT:PB_CHANNEL_A_SELECT];
    one = (sel != 4'h0) && ((sel & (sel - 4'h1)) == 4'h0);
    d = regs[chan_index(sel)];
    ctl = {pd, 1'b1, 1'b0, 12'h000};
    if (!one) begin
      w = p[PB_SINGLE] ? RB_DEFAULT_SGL : RB_DEFAULT_DBL;
    end else if (p[PB_SINGLE]) begin
      w = {d[DATA_W-1 -: 8], 8'h00};
    end else if (p[PB_RIGHT]) begin
      w = ctl | 16'(d);
    end else begin
      w = ctl | (16'(d) << (12 - DATA_W));
    end
    return w;
  endfunction : rb_word

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [2:0] f;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic [15:0] rbw;
    logic [7:0] b;
    logic nsel;
    logic need;
    logic [DATA_W-1:0] d;
    logic [1:0] pdn;
    logic clrb;
    logic ldb;
    f = 3'h0;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    b = 8'h00;
    nsel = 1'b0;
    need = 1'b0;
    pdn = PD_NORMAL;
    clrb = 1'b1;
    ldb = 1'b1;
    rbw = rb_word(r_r.ptr, r_r.inreg, r_r.pd);
    d = decode_data(r_r.ptr, r_r.word);
    r_nxt = r_r;

    // pins: a change counts once the second and third stages agree
    r_nxt.s1 = {address_select_pin_i, sda_i, scl_i};
    r_nxt.s2 = r_r.s1;
    r_nxt.s3 = r_r.s2;
    for (int i = 0; i < 3; i++) begin
      if (r_r.s2[i] == r_r.s3[i]) begin
        r_nxt.filt[i] = r_r.s3[i];
      end
    end
    f = r_nxt.filt;
    rise = f[0] & ~r_r.filt[0];
    fall = ~f[0] & r_r.filt[0];
    start = r_r.filt[0] & f[0] & r_r.filt[1] & ~f[1];
    stop = r_r.filt[0] & f[0] & ~r_r.filt[1] & f[1];

    // ----------------------------------------------------------------
    // link protocol
    // ----------------------------------------------------------------
    if (start) begin
      // a repeated start drops any unfinished write
      r_nxt.st = ST_ADDR;
      r_nxt.bitcnt = 4'h0;
      r_nxt.idx = 2'h0;
      r_nxt.wr_ok = 1'b0;
      r_nxt.sda_oe_n = 1'b1;
    end else if (stop) begin
      r_nxt.st = ST_IDLE;
      r_nxt.sda_oe_n = 1'b1;
      r_nxt.wr_ok = 1'b0;
      if (r_r.wr_ok) begin
        // a single byte carries no control bits: keep mode, load now
        if (!r_r.ptr[PB_SINGLE]) begin
          pdn = r_r.word[CW_POWERDOWN_MODE_HI:CW_POWERDOWN_MODE_LO];
          clrb = r_r.word[CW_CLEAR_ALL_BIT];
          ldb = r_r.word[CW_LOAD_OUTPUTS_BIT];
        end else begin
          pdn = r_r.pd;
          ldb = 1'b0;
        end
        r_nxt.pd = pdn;
        if (!clrb) begin
          r_nxt.inreg = '0;
          r_nxt.dacreg = '0;
          r_nxt.dirty = 4'h0;
        end else begin
          for (int c = 0; c < 4; c++) begin
            if (r_r.ptr[c]) begin
              r_nxt.inreg[c] = d;
              r_nxt.dirty[c] = 1'b1;
            end
          end
          // a high load bit keeps the DAC registers latched
          if (!ldb) begin
            for (int c = 0; c < 4; c++) begin
              if (r_nxt.dirty[c]) begin
                r_nxt.dacreg[c] = r_nxt.inreg[c];
                r_nxt.dirty[c] = 1'b0;
              end
            end
          end
        end
      end
    end else begin
      case (r_r.st)
        ST_IDLE: begin
          r_nxt.sda_oe_n = 1'b1;
        end
        ST_ADDR: begin
          if (rise) begin
            r_nxt.sh = {r_r.sh[6:0], f[1]};
            r_nxt.bitcnt = r_r.bitcnt + 4'h1;
          end
          if (fall && r_r.bitcnt == 4'h8) begin
            r_nxt.bitcnt = 4'h0;
            if (r_r.en &&
                r_r.sh[7:1] == {SLV_ADDR_HI, r_r.filt[2]}) begin
              r_nxt.sda_oe_n = 1'b0;
              r_nxt.rw = r_r.sh[0];
              r_nxt.st = ST_ACK;
            end else begin
              r_nxt.st = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (fall) begin
            r_nxt.bitcnt = 4'h0;
            if (r_r.rw) begin
              r_nxt.txsel = 1'b0;
              r_nxt.sh = rbw[15:8];
              r_nxt.sda_oe_n = rbw[15];
              r_nxt.st = ST_TX;
            end else begin
              r_nxt.sda_oe_n = 1'b1;
              r_nxt.st = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (rise) begin
            r_nxt.sh = {r_r.sh[6:0], f[1]};
            r_nxt.bitcnt = r_r.bitcnt + 4'h1;
          end
          if (fall && r_r.bitcnt == 4'h8) begin
            r_nxt.bitcnt = 4'h0;
            case (r_r.idx)
              2'h0: begin
                need = 1'b1;
                r_nxt.ptr = r_r.sh;
              end
              2'h1: begin
                need = 1'b1;
                r_nxt.word[15:8] = r_r.sh;
                r_nxt.wr_ok = r_r.ptr[PB_SINGLE];
              end
              2'h2: begin
                need = ~r_r.ptr[PB_SINGLE];
                r_nxt.word[7:0] = r_r.sh;
                r_nxt.wr_ok = need;
              end
              default: need = 1'b0;
            endcase
            if (need) begin
              r_nxt.sda_oe_n = 1'b0;
              r_nxt.idx = r_r.idx + 2'h1;
              r_nxt.st = ST_ACK;
            end else begin
              r_nxt.st = ST_IDLE;
            end
          end
        end
        ST_TX: begin
          if (rise) begin
            r_nxt.sh = {r_r.sh[6:0], 1'b0};
            r_nxt.bitcnt = r_r.bitcnt + 4'h1;
          end
          if (fall) begin
            if (r_r.bitcnt == 4'h8) begin
              r_nxt.sda_oe_n = 1'b1;
              r_nxt.st = ST_MACK;
            end else begin
              r_nxt.sda_oe_n = r_r.sh[7];
            end
          end
        end
        ST_MACK: begin
          if (rise) begin
            r_nxt.mack = ~f[1];
          end
          if (fall) begin
            if (r_r.mack) begin
              nsel = r_r.ptr[PB_SINGLE] ? 1'b0 : ~r_r.txsel;
              b = nsel ? rbw[7:0] : rbw[15:8];
              r_nxt.txsel = nsel;
              r_nxt.sh = b;
              r_nxt.sda_oe_n = b[7];
              r_nxt.bitcnt = 4'h0;
              r_nxt.st = ST_TX;
            end else begin
              r_nxt.st = ST_IDLE;
            end
          end
        end
        default: begin
          r_nxt.st = ST_IDLE;
          r_nxt.sda_oe_n = 1'b1;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // power-down exit delay
    // ----------------------------------------------------------------
    // counted from the end of the write, not from the 16th data clock
    if (r_nxt.pd != PD_NORMAL) begin
      r_nxt.active = 1'b0;
      r_nxt.exit_cnt = '0;
    end else if (!r_r.active) begin
      if (r_r.exit_cnt == EXW'(EXIT_CYC)) begin
        r_nxt.active = 1'b1;
      end else begin
        r_nxt.exit_cnt = r_r.exit_cnt + EXW'(1);
      end
    end

    // ----------------------------------------------------------------
    // wishbone slave, one wait state, unmapped reads give zero
    // ----------------------------------------------------------------
    r_nxt.ack = wb_i.cyc & wb_i.stb & ~r_r.ack;
    if (r_nxt.ack) begin
      r_nxt.rdat = 32'h0000_0000;
      if (wb_i.we) begin
        if (wb_i.adr == ADR_CTRL && wb_i.sel[0]) begin
          r_nxt.en = wb_i.dat[CTRL_EN_POS];
        end
      end else if (wb_i.adr == ADR_CTRL) begin
        r_nxt.rdat = 32'(r_r.en);
      end else if (wb_i.adr == ADR_STAT) begin
        r_nxt.rdat = 32'({r_r.st != ST_IDLE, r_r.active, r_r.dirty,
                          r_r.pd, r_r.ptr});
      end else if (wb_i.adr[7:4] == ADR_DAC_PAGE && wb_i.adr[1:0] == 2'h0)
      begin
        r_nxt.rdat = 32'(r_r.dacreg[wb_i.adr[3:2]]);
      end else if (wb_i.adr[7:4] == ADR_INP_PAGE && wb_i.adr[1:0] == 2'h0)
      begin
        r_nxt.rdat = 32'(r_r.inreg[wb_i.adr[3:2]]);
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_r <= '0;
      r_r.s1 <= PIN_RST;
      r_r.s2 <= PIN_RST;
      r_r.s3 <= PIN_RST;
      r_r.filt <= PIN_RST;
      r_r.st <= ST_IDLE;
      r_r.ptr <= PTR_RST;
      r_r.sda_oe_n <= 1'b1;
      r_r.pd <= PD_NORMAL;
      r_r.active <= 1'b1;
      r_r.en <= CTRL_EN_RST;
    end else if (ce_i) begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open-drain: the pin is only ever pulled low
  assign sda_o = 1'b0;
  assign sda_oe_n_o = r_r.sda_oe_n;
  assign wb_dat_o = r_r.rdat;
  assign wb_ack_o = r_r.ack;
  assign dac_code_o = r_r.dacreg;
  assign pd_mode_o = r_r.pd;
  assign out_active_o = r_r.active;

endmodule : qdac_core

/* dv/qdac_monitor.sv */
module qdac_monitor
  import qdac_pkg::*;
#(
  parameter int DATA_W = 12,
  parameter int EXIT_CYC = 50
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched ports
  input wire logic ce_i,
  input wire qdac_pkg::qdac_wb_req_s wb_i,
  input wire logic wb_ack_o,
  input wire logic scl_i,
  input wire logic sda_oe_n_o,
  input wire logic [3:0][DATA_W-1:0] dac_code_o,
  input wire logic [1:0] pd_mode_o,
  input wire logic out_active_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ----
  // power-down exit counter
  // ----
  logic [15:0] wait_r;
  logic [15:0] wait_nxt;
  always_comb begin
    wait_nxt = (pd_mode_o == PD_NORMAL && !out_active_o) ? wait_r + 16'h1 : '0;
  end
  always_ff @(posedge clk_i) begin
    wait_r <= rst_i ? 16'h0 : wait_nxt;
  end

  // ----
  // assertions
  // ----
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_answer: assert property
    ((ce_i && wb_i.cyc && wb_i.stb && !wb_ack_o) |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without request");
  a_pd_quiet: assert property
    (pd_mode_o != PD_NORMAL |-> !out_active_o)
    else $error("output active in power-down");
  a_exit_late: assert property (wait_r <= EXIT_CYC)
    else $error("output stayed off too long after power-down exit");
  a_exit_early: assert property ($rose(out_active_o) |->
    wait_r == EXIT_CYC)
    else $error("output woke too early after power-down exit");
  a_pd_keep: assert property ((pd_mode_o != PD_NORMAL &&
    $past(pd_mode_o) == PD_NORMAL) |-> $stable(dac_code_o))
    else $error("dac registers changed on entering power-down");
  a_sda_scl: assert property ($changed(sda_oe_n_o) |-> !scl_i)
    else $error("sda drive changed while scl high");
  a_rst_vals: assert property ($fell(rst_i) |-> sda_oe_n_o && !wb_ack_o &&
    pd_mode_o == PD_NORMAL && out_active_o && dac_code_o == '0)
    else $error("wrong state after reset");
  cover property (wb_ack_o && wb_i.we);
  cover property ($rose(out_active_o));
  cover property (pd_mode_o == PD_TRISTATE);
endmodule : qdac_monitor

bind qdac_core qdac_monitor #(.DATA_W(DATA_W), .EXIT_CYC(EXIT_CYC))
  u_qdac_monitor (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i),
  .wb_ack_o(wb_ack_o), .scl_i(scl_i), .sda_oe_n_o(sda_oe_n_o),
  .dac_code_o(dac_code_o), .pd_mode_o(pd_mode_o),
  .out_active_o(out_active_o));

/* dv/qdac_twi_master.sv */
module qdac_twi_master (
  // clock
  input wire logic clk_i,
  // two-wire lines
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----
  // bit timing: 5 clocks low, 3 high, 400 ns per bit
  // ----
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tk
  // sda moves late in the low phase so the filtered scl has fallen first
  task automatic bitx(input logic v, output logic r);
    tk(4);
    sda_o <= v;
    tk(1);
    r = sda_i;
    scl_o <= 1'b1;
    tk(3);
    scl_o <= 1'b0;
  endtask : bitx
  task automatic start();
    tk(4);
    sda_o <= 1'b1;
    tk(1);
    scl_o <= 1'b1;
    tk(3);
    sda_o <= 1'b0;
    tk(3);
    scl_o <= 1'b0;
  endtask : start
  task automatic stop();
    tk(4);
    sda_o <= 1'b0;
    tk(1);
    scl_o <= 1'b1;
    tk(3);
    sda_o <= 1'b1;
    tk(8);
  endtask : stop
  task automatic wbyte(input logic [7:0] d, output logic ok);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ok = !r;
  endtask : wbyte
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(nak, r);
  endtask : rbyte
endmodule : qdac_twi_master

/* dv/tb_top.sv */
module tb_top import qdac_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int EXIT = 20;
  localparam logic [7:0] AW = {SLV_ADDR_HI, 2'b10};
  localparam logic [7:0] AR = {SLV_ADDR_HI, 2'b11};
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic asel = 1'b1;
  qdac_wb_req_s wb_r = '0;
  logic [31:0] wb_dat;
  logic [31:0] q;
  logic [3:0][7:0] code;
  logic [1:0] pd;
  logic [7:0] b;
  logic wb_ack, sda_w, m_scl, m_sda, sd_o, oe_n, act, a;
  int fail_count = 0;
  int num_checks = 0;

  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // open drain: pulled up unless someone pulls low
  assign sda_w = m_sda & (oe_n | sd_o);

  qdac_core #(.DATA_W(8), .EXIT_CYC(EXIT)) u_qdac_core (.clk_i(clk_i),
    .rst_i(rst_i), .ce_i(1'b1), .wb_i(wb_r), .wb_dat_o(wb_dat),
    .wb_ack_o(wb_ack), .scl_i(m_scl), .sda_i(sda_w), .sda_o(sd_o),
    .sda_oe_n_o(oe_n), .address_select_pin_i(asel), .dac_code_o(code),
    .pd_mode_o(pd), .out_active_o(act));
  qdac_twi_master u_qdac_twi_master (.clk_i(clk_i), .sda_i(sda_w),
    .scl_o(m_scl), .sda_o(m_sda));

  // ----
  // tasks
  // ----
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    wb_r <= '{1'b1, 1'b1, w, ad, 4'hf, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack !== 1'b1);
    q = wb_dat;
    wb_r.cyc <= 1'b0;
    wb_r.stb <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic nak(input logic [7:0] ad);
    u_qdac_twi_master.start();
    u_qdac_twi_master.wbyte(ad, a);
    chk(32'(a), 32'h0);
    u_qdac_twi_master.stop();
  endtask : nak
  // single-byte data travels in w[7:0]
  task automatic wr(input logic [7:0] p, input logic [15:0] w, input int n);
    u_qdac_twi_master.start();
    u_qdac_twi_master.wbyte(AW, a);
    chk(32'(a), 32'h1);
    u_qdac_twi_master.wbyte(p, a);
    chk(32'(a), 32'h1);
    for (int i = n; i > 0; i--) begin
      u_qdac_twi_master.wbyte(w[8*i-1 -: 8], a);
    end
    u_qdac_twi_master.stop();
  endtask : wr
  // reads the word twice over to see the resend
  task automatic rd(input logic s, input logic [7:0] p, input int n,
                    input logic [15:0] e);
    u_qdac_twi_master.start();
    if (s) begin
      u_qdac_twi_master.wbyte(AW, a);
      u_qdac_twi_master.wbyte(p, a);
      u_qdac_twi_master.start();
    end
    u_qdac_twi_master.wbyte(AR, a);
    chk(32'(a), 32'h1);
    for (int k = 0; k < 2 * n; k++) begin
      u_qdac_twi_master.rbyte(k == 2 * n - 1, b);
      chk(32'(b), 32'(e[8*(n-k%n)-1 -: 8]));
    end
    u_qdac_twi_master.stop();
  endtask : rd

  // ----
  // tests
  // ----
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    wb(1'b0, ADR_STAT, 32'h0);
    chk(q, 32'h4000);
    rd(1'b0, 8'h00, 2, 16'h2000);
    nak(8'h18);
    wr(8'h01, 16'h3ab0, 2);
    wb(1'b0, {ADR_INP_PAGE, 4'h0}, 32'h0);
    chk(q, 32'hab);
    chk(32'(code), 32'h0);
    wb(1'b0, ADR_STAT, 32'h0);
    chk(32'(q[13:10]), 32'h1);
    rd(1'b1, 8'h01, 2, 16'h2ab0);
    wr(8'h2e, 16'h205c, 2);
    for (int i = 1; i < 4; i++) begin
      wb(1'b0, {ADR_INP_PAGE, 2'(i), 2'b00}, 32'h0);
      chk(q, 32'h5c);
    end
    chk(32'(code), 32'h5c5c5cab);
    wb(1'b0, ADR_STAT, 32'h0);
    chk(32'(q[13:10]), 32'h0);
    rd(1'b0, 8'h00, 2, 16'h2000);
    rd(1'b1, 8'h22, 2, 16'h205c);
    rd(1'b1, 8'h13, 1, 16'h0000);
    wr(8'h02, 16'h0077, 1);
    wb(1'b0, {ADR_INP_PAGE, 4'h4}, 32'h0);
    chk(q, 32'h5c);
    wr(8'h18, 16'h00c3, 1);
    chk(32'(code[3]), 32'hc3);
    rd(1'b0, 8'h00, 1, 16'h00c3);
    for (int m = 1; m < 4; m++) begin
      wr(8'h01, {2'(m), 14'h3ab0}, 2);
      chk(32'(pd), 32'(m));
      chk(32'(act), 32'h0);
      chk(32'(code), 32'hc35c5cab);
      wr(8'h01, 16'h3ab0, 2);
      chk(32'(act), 32'h0);
      repeat (EXIT + 4) @(posedge clk_i);
      chk(32'(act), 32'h1);
    end
    wb(1'b1, ADR_CTRL, 32'h0);
    nak(AW);
    wb(1'b1, ADR_CTRL, 32'h1);
    wb(1'b0, 8'hfc, 32'hffffffff);
    chk(q, 32'h0);
    wr(8'h01, 16'h0000, 2);
    chk(32'(code), 32'h0);
    wb(1'b0, {ADR_INP_PAGE, 4'hc}, 32'h0);
    chk(q, 32'h0);
    // the other strap level moves the device to the neighbouring address
    asel <= 1'b0;
    repeat (6) @(posedge clk_i);
    nak(AW);
    u_qdac_twi_master.start();
    u_qdac_twi_master.wbyte({SLV_ADDR_HI, 2'b00}, a);
    chk(32'(a), 32'h1);
    u_qdac_twi_master.stop();
    end_sim();
  end

  // whole sequence needs well under a millisecond
  initial begin
    #2000000;
    fail_count++;
    end_sim();
  end
endmodule : tb_top
